/* File: clkrst_pkg.sv */
// Package with register map, field layouts and timing constants of the clock and reset block
package clkrst_pkg;

  // Register byte addresses (one aligned word each)
  localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
  localparam logic [7:0] ADDR_CLK_CFG = 8'h04;
  localparam logic [7:0] ADDR_TX_CFG = 8'h08;
  localparam logic [7:0] ADDR_ADC_CFG = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam logic [7:0] ADDR_CARRIER = 8'h44;
  localparam logic [7:0] ADDR_IQ = 8'h48;
  localparam logic [7:0] ADDR_DAC_OUT = 8'h4C;

  // Field positions
  localparam int SWRST_BIT = 5;
  localparam int SWPD_BIT = 5;
  localparam int ADCSEL_BIT = 7;
  localparam int TXMUX_BIT = 0;
  localparam int MULT_LO = 0;
  localparam int INTERP_LO = 2;
  localparam int REFDIV_LO = 8;

  // Reset values
  localparam logic [7:0] PORT_CFG_RST = 8'h00;
  localparam logic [1:0] MULT_RST = 2'h0;
  localparam logic [1:0] INTERP_RST = 2'h0;
  localparam logic [5:0] REFDIV_RST = 6'h00;
  localparam logic [7:0] TX_CFG_RST = 8'h00;
  localparam logic [7:0] ADC_CFG_RST = 8'h00;

  // Multiplier codes map to 1, 2, 3, 8; interpolation codes to 1, 2, 4
  localparam logic [3:0] MULT_X1 = 4'h1;
  localparam logic [3:0] MULT_X2 = 4'h2;
  localparam logic [3:0] MULT_X3 = 4'h3;
  localparam logic [3:0] MULT_X8 = 4'h8;
  localparam logic [2:0] INTERP_X1 = 3'h1;
  localparam logic [2:0] INTERP_X2 = 3'h2;
  localparam logic [2:0] INTERP_X4 = 3'h4;
  localparam int SYS_TO_MCLK_DIV = 4;
  localparam logic [5:0] REFDIV_MIN = 6'h02;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PLL_SETTLE_US = 1000;
  localparam int PLL_SETTLE_CYC = (PLL_SETTLE_US * 1000) / CLK_PERIOD_NS;
  localparam logic [6:0] CIC_FLUSH_MCLK = 7'h50;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Quadrature carrier sample pair
  typedef struct packed {
    logic signed [11:0] cos_val;
    logic signed [11:0] sin_val;
  } carrier_type;

  // Transmit symbol components
  typedef struct packed {
    logic signed [11:0] i_val;
    logic signed [11:0] q_val;
  } iq_type;

  // Clock enables produced for the surrounding chip
  typedef struct packed {
    logic dac;
    logic txport;
    logic mclk;
    logic adc;
    logic aux_clock_out;
  } clk_en_type;

endpackage

/* File: clk_divider.sv */
// Programmable modulo counter issuing one enable pulse every N input enables
`timescale 1ns/1ps
`default_nettype none
module clk_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic in_en,
  input wire logic [6:0] ratio,
  output logic out_en
);

  logic [6:0] cnt_q;

  // Counts input enables, wraps at ratio-1; held cleared while stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 7'h00;
    end else if (!run) begin
      cnt_q <= 7'h00;
    end else if (in_en) begin
      if (cnt_q >= ratio - 7'h01) begin
        cnt_q <= 7'h00;
      end else begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end

  assign out_en = run && in_en && (cnt_q >= ratio - 7'h01);

endmodule // clk_divider
`default_nettype wire

/* File: clock_reset_tx_powerdown_ctrl.sv */
// Clock generation, reset and transmit power-down controller with AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module clock_reset_tx_powerdown_ctrl #(
  parameter int PLL_SETTLE_CYCLES = clkrst_pkg::PLL_SETTLE_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic TX_POWERDOWN_N,
  input wire logic OSC_INPUT,
  output logic OSC_BUFFER_OUT,
  output logic AUX_CLOCK_OUT,
  output clkrst_pkg::clk_en_type CLK_EN,
  output logic CIC_RESET,
  output logic PLL_LOCKED,
  output logic TX_DATA_VALID,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // Configuration registers
  logic [7:0] port_cfg_q;
  logic [1:0] mult_sel_q;
  logic [1:0] interp_sel_q;
  logic [5:0] refdiv_q;
  logic [7:0] tx_cfg_q;
  logic [7:0] adc_cfg_q;
  clkrst_pkg::carrier_type carrier_q;
  clkrst_pkg::iq_type iq_q;
  logic [11:0] dac_sample_q;
  // Bus state
  logic [7:0] aw_addr_q;
  logic aw_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_held_q;
  logic [1:0] bresp_q;
  logic bvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;
  // Control state
  logic [31:0] settle_cnt_q;
  logic [6:0] cic_cnt_q;
  logic pd_prev_q;
  logic soft_rst;
  logic wr_fire;
  logic wr_ok;
  logic tx_pd;
  logic clocks_run;
  logic [3:0] mult_val;
  logic [2:0] interp_val;
  logic sys_pulse;
  logic mclk_en;
  logic ref_en;
  logic mclk_half_en;
  logic dac_en;
  logic txport_en;
  logic ref_tgl_q;
  logic [6:0] txport_ratio;

  typedef enum logic [1:0] {
    PLL_IDLE_type_s,
    PLL_SETTLE_type_s,
    PLL_LOCK_type_s
  } pll_state_type;
  pll_state_type pll_q;

  // Maps the two-bit multiplier code onto the permitted values
  function automatic logic [3:0] mult_decode(input logic [1:0] code);
    unique case (code)
      2'h0: mult_decode = clkrst_pkg::MULT_X1;
      2'h1: mult_decode = clkrst_pkg::MULT_X2;
      2'h2: mult_decode = clkrst_pkg::MULT_X3;
      2'h3: mult_decode = clkrst_pkg::MULT_X8;
    endcase
  endfunction

  // Maps the interpolation code; the spare code falls back to 4
  function automatic logic [2:0] interp_decode(input logic [1:0] code);
    unique case (code)
      2'h0: interp_decode = clkrst_pkg::INTERP_X1;
      2'h1: interp_decode = clkrst_pkg::INTERP_X2;
      default: interp_decode = clkrst_pkg::INTERP_X4;
    endcase
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d,
                                      input logic [3:0] s, input int idx);
    lane = s[idx] ? d[idx*8 +: 8] : old;
  endfunction

  assign mult_val = mult_decode(mult_sel_q);
  assign interp_val = interp_decode(interp_sel_q);

  // Write channel handshakes; address and data taken in either order
  assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
  assign S_AXI_WREADY = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_ok = (aw_addr_q == clkrst_pkg::ADDR_PORT_CFG) || (aw_addr_q == clkrst_pkg::ADDR_CLK_CFG) ||
                 (aw_addr_q == clkrst_pkg::ADDR_TX_CFG) || (aw_addr_q == clkrst_pkg::ADDR_ADC_CFG) ||
                 (aw_addr_q == clkrst_pkg::ADDR_CARRIER) || (aw_addr_q == clkrst_pkg::ADDR_IQ);
  // Software reset fires when a write lands with the reset bit set
  assign soft_rst = wr_fire && (aw_addr_q == clkrst_pkg::ADDR_PORT_CFG) && w_strb_q[0] &&
                    w_data_q[clkrst_pkg::SWRST_BIT];

  // Captures the write address and data beats
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aw_addr_q <= 8'h00;
      aw_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      w_held_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr_q <= S_AXI_AWADDR[7:0];
        aw_held_q <= 1'b1;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
        w_held_q <= 1'b1;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q <= clkrst_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? clkrst_pkg::RESP_OKAY : clkrst_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  // Port register survives software reset
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      port_cfg_q <= clkrst_pkg::PORT_CFG_RST;
    end else if (wr_fire && aw_addr_q == clkrst_pkg::ADDR_PORT_CFG) begin
      port_cfg_q <= lane(port_cfg_q, w_data_q, w_strb_q, 0);
    end
  end

  // Clock, tx and ADC configuration; software reset restores defaults
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      mult_sel_q <= clkrst_pkg::MULT_RST;
      interp_sel_q <= clkrst_pkg::INTERP_RST;
      refdiv_q <= clkrst_pkg::REFDIV_RST;
      tx_cfg_q <= clkrst_pkg::TX_CFG_RST;
      adc_cfg_q <= clkrst_pkg::ADC_CFG_RST;
    end else if (soft_rst) begin
      mult_sel_q <= clkrst_pkg::MULT_RST;
      interp_sel_q <= clkrst_pkg::INTERP_RST;
      refdiv_q <= clkrst_pkg::REFDIV_RST;
      tx_cfg_q <= clkrst_pkg::TX_CFG_RST;
      adc_cfg_q <= clkrst_pkg::ADC_CFG_RST;
    end else if (wr_fire) begin
      if (aw_addr_q == clkrst_pkg::ADDR_CLK_CFG) begin
        if (w_strb_q[0]) begin
          mult_sel_q <= w_data_q[clkrst_pkg::MULT_LO +: 2];
          interp_sel_q <= w_data_q[clkrst_pkg::INTERP_LO +: 2];
        end
        if (w_strb_q[1]) begin
          refdiv_q <= w_data_q[clkrst_pkg::REFDIV_LO +: 6];
        end
      end
      if (aw_addr_q == clkrst_pkg::ADDR_TX_CFG) begin
        tx_cfg_q <= lane(tx_cfg_q, w_data_q, w_strb_q, 0);
      end
      if (aw_addr_q == clkrst_pkg::ADDR_ADC_CFG) begin
        adc_cfg_q <= lane(adc_cfg_q, w_data_q, w_strb_q, 0);
      end
    end
  end

  // Carrier and symbol samples feeding the quadrature mixer
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      carrier_q <= '0;
      iq_q <= '0;
    end else if (wr_fire && aw_addr_q == clkrst_pkg::ADDR_CARRIER) begin
      carrier_q <= w_data_q[23:0];
    end else if (wr_fire && aw_addr_q == clkrst_pkg::ADDR_IQ) begin
      iq_q <= w_data_q[23:0];
    end
  end

  // Mixer: I*cos + Q*sin, scaled back to 12 bits, on each DAC tick
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dac_sample_q <= 12'h000;
    end else if (dac_en) begin
      dac_sample_q <= 12'(((25'(iq_q.i_val) * 25'(carrier_q.cos_val)) +
                           (25'(iq_q.q_val) * 25'(carrier_q.sin_val))) >>> 11);
    end
  end

  // PLL settling timer restarts on reset, soft reset or multiplier change
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pll_q <= PLL_IDLE_type_s;
      settle_cnt_q <= 32'h0000_0000;
    end else if (soft_rst || (wr_fire && aw_addr_q == clkrst_pkg::ADDR_CLK_CFG && w_strb_q[0] &&
                 w_data_q[clkrst_pkg::MULT_LO +: 2] != mult_sel_q)) begin
      pll_q <= PLL_SETTLE_type_s;
      settle_cnt_q <= 32'h0000_0000;
    end else begin
      unique case (pll_q)
        PLL_IDLE_type_s: pll_q <= PLL_SETTLE_type_s;
        PLL_SETTLE_type_s: begin
          if (settle_cnt_q >= 32'(PLL_SETTLE_CYCLES - 1)) begin
            pll_q <= PLL_LOCK_type_s;
          end else begin
            settle_cnt_q <= settle_cnt_q + 32'h0000_0001;
          end
        end
        PLL_LOCK_type_s: pll_q <= PLL_LOCK_type_s;
      endcase
    end
  end

  assign PLL_LOCKED = (pll_q == PLL_LOCK_type_s);
  assign clocks_run = !RST;
  assign tx_pd = !TX_POWERDOWN_N || tx_cfg_q[clkrst_pkg::SWPD_BIT];

  // System tick per CLK_SYS edge, gated by transmit power-down into DAC ticks; the multiplier is not applied
  assign sys_pulse = clocks_run;
  assign dac_en = sys_pulse && !tx_pd;

  // Master clock is system clock divided by four
  clk_divider u_mclk_div (
    .clk(CLK_SYS),
    .rst(RST),
    .run(clocks_run),
    .in_en(sys_pulse),
    .ratio(7'(clkrst_pkg::SYS_TO_MCLK_DIV)),
    .out_en(mclk_en)
  );

  // Tx port rate: DAC / K, or 2*DAC / K with multiplexer enabled (DAC rate for K of 1)
  assign txport_ratio = tx_cfg_q[clkrst_pkg::TXMUX_BIT] ? 7'(interp_val >> 1) : 7'(interp_val);

  clk_divider u_tx_div (
    .clk(CLK_SYS),
    .rst(RST),
    .run(!tx_pd),
    .in_en(dac_en),
    .ratio((txport_ratio == 7'h00) ? 7'h01 : txport_ratio),
    .out_en(txport_en)
  );

  // ADC clock is MCLK/2 unless the system tick is selected
  clk_divider u_adc_div (
    .clk(CLK_SYS),
    .rst(RST),
    .run(clocks_run),
    .in_en(mclk_en),
    .ratio(7'h02),
    .out_en(mclk_half_en)
  );

  // Aux half period is 2R system ticks, that is R/2 master clocks, so one full period is R master clocks
  clk_divider u_ref_div (
    .clk(CLK_SYS),
    .rst(RST),
    .run(clocks_run && refdiv_q >= clkrst_pkg::REFDIV_MIN),
    .in_en(sys_pulse),
    .ratio({refdiv_q, 1'b0}),
    .out_en(ref_en)
  );

  // Toggles the aux output at each divider tick
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ref_tgl_q <= 1'b0;
    end else if (ref_en) begin
      ref_tgl_q <= !ref_tgl_q;
    end
  end

  assign OSC_BUFFER_OUT = OSC_INPUT;
  assign AUX_CLOCK_OUT = (refdiv_q == 6'h00) ? OSC_INPUT : ref_tgl_q;

  // Clock enables to the datapath; ADC bus follows MCLK/2 or the system tick, IF words follow the DAC tick
  assign CLK_EN.dac = dac_en;
  assign CLK_EN.txport = txport_en && !tx_pd;
  assign CLK_EN.mclk = mclk_en;
  assign CLK_EN.adc = adc_cfg_q[clkrst_pkg::ADCSEL_BIT] ? sys_pulse : mclk_half_en;
  assign CLK_EN.aux_clock_out = ref_en && !ref_tgl_q;

  // CIC reset held while powered down and 80 MCLK cycles after release
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cic_cnt_q <= 7'h00;
      pd_prev_q <= 1'b1;
    end else begin
      pd_prev_q <= tx_pd;
      if (tx_pd) begin
        cic_cnt_q <= 7'h00;
      end else if (pd_prev_q) begin
        cic_cnt_q <= clkrst_pkg::CIC_FLUSH_MCLK;
      end else if (mclk_en && cic_cnt_q != 7'h00) begin
        cic_cnt_q <= cic_cnt_q - 7'h01;
      end
    end
  end

  assign CIC_RESET = tx_pd || pd_prev_q || (cic_cnt_q != 7'h00);
  assign TX_DATA_VALID = PLL_LOCKED && !tx_pd && !CIC_RESET;

  // Read channel
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= clkrst_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q <= clkrst_pkg::RESP_OKAY;
      unique case (S_AXI_ARADDR[7:0])
        clkrst_pkg::ADDR_PORT_CFG: rdata_q <= {24'h000000, port_cfg_q};
        clkrst_pkg::ADDR_CLK_CFG: rdata_q <= {18'h00000, refdiv_q, 4'h0, interp_sel_q, mult_sel_q};
        clkrst_pkg::ADDR_TX_CFG: rdata_q <= {24'h000000, tx_cfg_q};
        clkrst_pkg::ADDR_ADC_CFG: rdata_q <= {24'h000000, adc_cfg_q};
        clkrst_pkg::ADDR_STATUS: rdata_q <= {28'h0000000, TX_DATA_VALID, CIC_RESET, tx_pd, PLL_LOCKED};
        clkrst_pkg::ADDR_CARRIER: rdata_q <= {8'h00, carrier_q};
        clkrst_pkg::ADDR_IQ: rdata_q <= {8'h00, iq_q};
        clkrst_pkg::ADDR_DAC_OUT: rdata_q <= {20'h00000, dac_sample_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= clkrst_pkg::RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

endmodule // clock_reset_tx_powerdown_ctrl
`default_nettype wire

/* File: clock_reset_tx_powerdown_ctrl_chk.sv */
// Port-level assertions for the clock, reset and transmit power-down controller
`timescale 1ns/1ps
`default_nettype none
module clock_reset_tx_powerdown_ctrl_chk #(
  parameter int PLL_SETTLE_CYCLES = 20
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic TX_POWERDOWN_N,
  input wire logic OSC_INPUT,
  input wire logic OSC_BUFFER_OUT,
  input wire clkrst_pkg::clk_en_type CLK_EN,
  input wire logic CIC_RESET,
  input wire logic PLL_LOCKED,
  input wire logic TX_DATA_VALID,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID
);
  int hold_q;
  int unl_q;
  // Cycles of filter reset with the pin high, and cycles spent unlocked
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      hold_q <= 0;
      unl_q <= 0;
    end else begin
      hold_q <= (CIC_RESET && TX_POWERDOWN_N) ? hold_q + 1 : 0;
      unl_q <= PLL_LOCKED ? 0 : unl_q + 1;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  osc_buffer_a: assert property (OSC_BUFFER_OUT == OSC_INPUT)
    else $error("oscillator buffer differs from input");
  valid_gate_a: assert property (TX_DATA_VALID |-> PLL_LOCKED && !CIC_RESET && $past(TX_POWERDOWN_N))
    else $error("data valid without lock or power-up");
  pd_stop_a: assert property (!TX_POWERDOWN_N [*2] |-> CIC_RESET && !CLK_EN.dac && !CLK_EN.txport)
    else $error("power-down did not stop clocks");
  cic_hold_a: assert property ($fell(CIC_RESET) |-> hold_q >= 316 && hold_q <= 330)
    else $error("filter reset released after wrong span");
  lock_settle_a: assert property ($rose(PLL_LOCKED) |->
      unl_q >= PLL_SETTLE_CYCLES - 2 && unl_q <= PLL_SETTLE_CYCLES + 4)
    else $error("lock after wrong settling time");
  reset_unlock_a: assert property ($past(RST) |-> !PLL_LOCKED [*8])
    else $error("locked too soon after reset");
  mclk_gap_a: assert property (CLK_EN.mclk |=> !CLK_EN.mclk [*3] ##1 CLK_EN.mclk)
    else $error("master clock tick not every fourth cycle");
  b_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=>
      !S_AXI_AWREADY ##1 S_AXI_BVALID && !S_AXI_AWREADY)
    else $error("write response missing");
  r_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read response missing");
  cover property ($fell(CIC_RESET));
  cover property ($rose(PLL_LOCKED));
  cover property ($rose(TX_DATA_VALID));
endmodule // clock_reset_tx_powerdown_ctrl_chk
bind clock_reset_tx_powerdown_ctrl clock_reset_tx_powerdown_ctrl_chk #(.PLL_SETTLE_CYCLES(PLL_SETTLE_CYCLES)) u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .TX_POWERDOWN_N(TX_POWERDOWN_N), .OSC_INPUT(OSC_INPUT),
  .OSC_BUFFER_OUT(OSC_BUFFER_OUT), .CLK_EN(CLK_EN), .CIC_RESET(CIC_RESET), .PLL_LOCKED(PLL_LOCKED),
  .TX_DATA_VALID(TX_DATA_VALID), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID));
`default_nettype wire

/* File: host_model.sv */
// Host controller model driving the oscillator and the power-down pin
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic locked,
  input wire logic want_on,
  output logic osc,
  output logic pd_n
);
  logic [1:0] div_q;
  // Oscillator stand-in, one level change every third cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 2'h0;
      osc <= 1'b0;
    end else begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      if (div_q == 2'h2) osc <= ~osc;
    end
  end
  // Pin low through reset and settling, pulsed low again whenever lock is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pd_n <= 1'b0;
    else pd_n <= want_on && locked;
  end
endmodule // host_model
`default_nettype wire

/* File: test_clock_reset_tx_powerdown_ctrl.sv */
// Self-checking bench for the clock, reset and transmit power-down controller
`timescale 1ns/1ps
`default_nettype none
module test_clock_reset_tx_powerdown_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic want_on = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic pd_n, osc, osc_buf, aux, cic, locked, valid, awready, wready, bvalid, arready, rvalid, ta, tw;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, got, v, c2;
  logic [31:0] seed = 32'h00009A9F;
  logic [3:0] wstrb = 4'hF;
  clkrst_pkg::clk_en_type en;
  int bad_count = 0;
  int checks = 0;
  int n, r;
  int c [6];
  clock_reset_tx_powerdown_ctrl #(.PLL_SETTLE_CYCLES(20)) u_clock_reset_tx_powerdown_ctrl (
    .CLK_SYS(clk), .RST(rst), .TX_POWERDOWN_N(pd_n), .OSC_INPUT(osc), .OSC_BUFFER_OUT(osc_buf),
    .AUX_CLOCK_OUT(aux), .CLK_EN(en), .CIC_RESET(cic), .PLL_LOCKED(locked), .TX_DATA_VALID(valid),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));
  host_model u_host_model (.clk(clk), .rst(rst), .locked(locked), .want_on(want_on), .osc(osc), .pd_n(pd_n));
  // Clock generator
  initial begin
    forever #5 clk = ~clk;
  end
  // Xorshift source for repeatable stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Two 12-bit fields kept in 11-bit signed range so the sum cannot overflow
  function automatic logic [31:0] pair(input logic [31:0] x);
    return {8'h00, x[22], x[22:12], x[10], x[10:0]};
  endfunction
  // Expected DAC sample from carrier and symbol words
  function automatic logic [31:0] dac_exp(input logic [31:0] car, input logic [31:0] iq);
    logic signed [24:0] acc;
    acc = $signed(iq[23:12]) * $signed(car[23:12]) + $signed(iq[11:0]) * $signed(car[11:0]);
    return {20'h0, acc[22:11]};
  endfunction
  // Compare one value with its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts, verdict and end of run
  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta || awready;
      tw = tw || wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    ta = 1'b0;
    while (!ta) begin
      @(negedge clk);
      ta = bvalid;
      resp = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask
  // Register read, data and response left in got and resp
  task automatic rd(input logic [7:0] a);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    ta = 1'b0;
    while (!ta) begin
      @(negedge clk);
      ta = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    ta = 1'b0;
    while (!ta) begin
      @(negedge clk);
      ta = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Read and compare the masked word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(resp, clkrst_pkg::RESP_OKAY);
    chk(got & m, e);
  endtask
  // Write, then read back the masked fields
  task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    wr(a, d);
    chk(resp, clkrst_pkg::RESP_OKAY);
    rdchk(a, m, d & m);
  endtask
  // Wait up to lim cycles for lock (sel 0) or data valid (sel 1)
  task automatic await(input int sel, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (n < lim && !(sel == 0 ? locked : valid));
    @(posedge clk);
  endtask
  // Count clock-enable ticks and oscillator copy faults over 96 cycles
  task automatic tally();
    c = '{default: 0};
    repeat (96) begin
      @(negedge clk);
      c[0] += en.dac;
      c[1] += en.txport;
      c[2] += en.mclk;
      c[3] += en.adc;
      c[4] += (aux !== osc) + (osc_buf !== osc);
      c[5] += en.aux_clock_out;
    end
    @(posedge clk);
  endtask
  // Watchdog, about twenty times the expected run length
  initial begin
    #400000;
    bad_count++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(clkrst_pkg::ADDR_PORT_CFG, 32'hFFFFFFFF, 32'h0);
    rdchk(clkrst_pkg::ADDR_CLK_CFG, 32'hFFFFFFFF, 32'h0);
    rdchk(clkrst_pkg::ADDR_TX_CFG, 32'hFFFFFFFF, 32'h0);
    rdchk(clkrst_pkg::ADDR_ADC_CFG, 32'hFFFFFFFF, 32'h0);
    rdchk(clkrst_pkg::ADDR_STATUS, 32'hF, 32'h6);
    rd(8'h10);
    chk(resp, clkrst_pkg::RESP_SLVERR);
    chk(got, 32'h0);
    wr(8'h14, rnd());
    chk(resp, clkrst_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      wrchk(clkrst_pkg::ADDR_CLK_CFG, v, 32'h3F0F);
      wrchk(clkrst_pkg::ADDR_TX_CFG, v & 32'h1, 32'h21);
      wrchk(clkrst_pkg::ADDR_ADC_CFG, v, 32'h80);
    end
    wr(clkrst_pkg::ADDR_CLK_CFG, 32'h0);
    wr(clkrst_pkg::ADDR_TX_CFG, 32'h0);
    await(0, 100);
    chk(locked, 1'b1);
    want_on <= 1'b1;
    await(1, 600);
    chk(n >= 316 && n <= 334, 1'b1);
    for (int i = 0; i < 6; i++) begin
      c2 = (i == 0) ? 32'h00C00C00 : pair(rnd());
      v = (i == 0) ? 32'h00C00C00 : pair(rnd());
      wr(clkrst_pkg::ADDR_CARRIER, c2);
      wr(clkrst_pkg::ADDR_IQ, v);
      rdchk(clkrst_pkg::ADDR_DAC_OUT, 32'hFFF, dac_exp(c2, v));
    end
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 2; m++) begin
        wr(clkrst_pkg::ADDR_CLK_CFG, 32'(k) << 2);
        wr(clkrst_pkg::ADDR_TX_CFG, 32'(m));
        tally();
        r = ((1 << k) >> m > 0) ? (1 << k) >> m : 1;
        chk(c[1], 96 / r);
        chk(c[0], 96);
        chk(c[2], 24);
        chk(c[4], 0);
      end
    end
    for (int s = 0; s < 2; s++) begin
      wr(clkrst_pkg::ADDR_ADC_CFG, 32'(s) << 7);
      tally();
      chk(c[3], s ? 96 : 12);
    end
    wr(clkrst_pkg::ADDR_TX_CFG, 32'h20);
    repeat (2) @(negedge clk);
    chk({cic, valid}, 2'b10);
    @(posedge clk);
    tally();
    chk(c[0] + c[1], 0);
    want_on <= 1'b0;
    wr(clkrst_pkg::ADDR_TX_CFG, 32'h0);
    want_on <= 1'b1;
    await(1, 600);
    chk(valid, 1'b1);
    wr(clkrst_pkg::ADDR_CLK_CFG, 32'h1);
    repeat (2) @(negedge clk);
    chk(locked, 1'b0);
    @(posedge clk);
    await(0, 100);
    chk(locked, 1'b1);
    wr(clkrst_pkg::ADDR_PORT_CFG, 32'hE0);
    repeat (2) @(negedge clk);
    chk(locked, 1'b0);
    @(posedge clk);
    rdchk(clkrst_pkg::ADDR_CLK_CFG, 32'hFFFFFFFF, 32'h0);
    rdchk(clkrst_pkg::ADDR_PORT_CFG, 32'hDF, 32'hC0);
    // Divider lane only: multiplier lane must stay, aux runs at MCLK/2
    wstrb <= 4'h2;
    wr(clkrst_pkg::ADDR_CLK_CFG, 32'h0000_0203);
    wstrb <= 4'hF;
    rdchk(clkrst_pkg::ADDR_CLK_CFG, 32'h3F0F, 32'h0000_0200);
    tally();
    chk(c[5], 96 / (clkrst_pkg::SYS_TO_MCLK_DIV * 2));
    // Mid-run hardware reset held 100 ns, then defaults and unlocked state
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(clkrst_pkg::ADDR_PORT_CFG, 32'hFFFFFFFF, 32'h0);
    rdchk(clkrst_pkg::ADDR_STATUS, 32'hF, 32'h6);
    final_report();
  end
endmodule // test_clock_reset_tx_powerdown_ctrl
`default_nettype wire
